// *** rtl/dsadc_ctrl_pkg.sv ***
// Package: constants and types for the delta-sigma conversion controller
`default_nettype none
package dsadc_ctrl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int RES_W = 12;
    localparam int RES_W_LOW = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_RATE = 4'h5;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_LOWRES_BIT = 4;
    localparam int CTRL_STOP_BIT = 5;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_OVR_BIT = 2;
    localparam int IRQ_W = 2;
    localparam int IRQ_EOC_BIT = 0;
    localparam int IRQ_OVR_BIT = 1;
    localparam int PRIME_CONV = 3;
    localparam int HIST_DEPTH = 4;
    localparam int RATE_W = 16;
    localparam logic [RATE_W-1:0] RATE_RESET = 16'h0040;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_MULTI = 2'b01,
        MODE_CONT = 2'b10,
        MODE_TURBO = 2'b11
    } mode_type;
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_CONVERT = 2'b01,
        ST_HOLD = 2'b10
    } state_type;
endpackage
`default_nettype wire

// *** rtl/dsadc_conv_if.sv ***
// Interface: conversion strobe and sample between controller and decimator
`default_nettype none
interface dsadc_conv_if #(parameter int RES_W = 12);
    logic             clear;
    logic             tick;
    logic [RES_W-1:0] sample;
    logic [RES_W-1:0] result;
    logic             ready;
    modport ctrl (output clear, output tick, output sample, input result, input ready);
    modport decim (input clear, input tick, input sample, output result, output ready);
endinterface
`default_nettype wire

// *** rtl/dsadc_decimator.sv ***
// Decimator history: output depends on the last four conversions
`default_nettype none
module dsadc_decimator
    import dsadc_ctrl_pkg::*;
#(
    parameter int RES_W = 12,
    parameter int DEPTH = 4
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    dsadc_conv_if.decim cv
);
    localparam int SUM_W = RES_W + $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

    initial begin
        if (DEPTH != HIST_DEPTH) $error("decimator depth must be four");
    end

    logic [RES_W-1:0] hist_r [DEPTH];
    logic [CNT_W-1:0] fill_r;
    logic [SUM_W-1:0] sum;

    always_comb begin
        sum = '0;
        for (int i = 0; i < DEPTH; i++) begin
            sum = sum + SUM_W'(hist_r[i]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_hist
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    hist_r[g] <= '0;
                end else if (ce && cv.clear) begin
                    hist_r[g] <= '0;
                end else if (ce && cv.tick) begin
                    hist_r[g] <= (g == 0) ? cv.sample : hist_r[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // Count samples since the last clear; valid from the fourth
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fill_r <= '0;
        end else if (ce && cv.clear) begin
            fill_r <= '0;
        end else if (ce && cv.tick && fill_r != FULL) begin
            fill_r <= fill_r + 1'b1;
        end
    end

    assign cv.result = sum[SUM_W-1 -: RES_W];
    assign cv.ready = (fill_r == FULL);
endmodule // dsadc_decimator
`default_nettype wire

// *** rtl/dsadc_conv_ctrl.sv ***
// Top: delta-sigma conversion sequencer with register port and interrupt
//
// Operation
// - Four modes are offered: single sample, multi sample, continuous and multi sample turbo.
// - Any mode starts on the control start bit or on the hardware start input.
// - Completion sets a status bit and raises end of conversion until the result is read.
// - Results depend on the last four samples and are invalid until the fourth after a switch.
// - Single mode waits in standby, runs four conversions and reports after the fourth.
// - Single mode returns to standby once the result is read and waits for the next start.
// - Continuous mode reports after three priming periods, then every sample period.
// - Multi mode clears and re-primes the decimator between samples.
// - Multi mode starts the next sample by itself when one completes.
// - End of conversion rises after every reported result, not after priming conversions, and can drive an interrupt or DMA.
// - Results are 12 bits at the base rate or 8 bits at twice that rate.
//
// Implementation choices: the plain strobed port and the register offsets.
`default_nettype none
module dsadc_conv_ctrl
    import dsadc_ctrl_pkg::*;
#(
    parameter int RES_BITS = 12,
    parameter int RATE_BITS = 16
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  reset_n,
    input  wire logic                                  clk_en,
    input  wire logic [dsadc_ctrl_pkg::ADDR_W-1:0]      addr,
    input  wire logic [dsadc_ctrl_pkg::DATA_W-1:0]      wdata,
    input  wire logic                                  wr_stb,
    input  wire logic                                  rd_stb,
    output var  logic [dsadc_ctrl_pkg::DATA_W-1:0]      rdata,
    input  wire logic                                  soc_in,
    input  wire logic                                  dma_ack,
    input  wire logic [RES_BITS-1:0]                    mod_sample,
    output var  logic                                  mod_run,
    output var  logic                                  mod_clear,
    output var  logic                                  eoc_out,
    output var  logic                                  irq
);
    import dsadc_ctrl_pkg::*;

    initial begin
        if (RES_BITS != RES_W) $error("result width must be twelve");
        if (RATE_BITS != RATE_W) $error("rate field width must be sixteen");
    end

    localparam int PC_W = 2;
    localparam logic [PC_W-1:0] PRIME_LAST = PC_W'(PRIME_CONV);

    function automatic logic is_multi(input mode_type m);
        return (m == MODE_MULTI) || (m == MODE_TURBO);
    endfunction

    // Reset release
    logic rs1_r;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    dsadc_conv_if #(.RES_W(RES_BITS)) cv ();

    dsadc_decimator #(.RES_W(RES_BITS), .DEPTH(HIST_DEPTH)) dsadc_decimator_i (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (clk_en),
        .cv      (cv)
    );

    // Registers
    mode_type         mode_r;
    logic             en_r;
    logic             lowres_r;
    logic [RATE_W-1:0] rate_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic             done_r;
    logic             ovr_r;
    logic [RES_W-1:0] result_r;
    state_type        state_r;
    logic [RATE_W-1:0] div_r;
    logic [PC_W-1:0]  prime_r;
    logic             soc_d_r;
    logic             pend_r;

    // Decode
    wire wr_ctrl = wr_stb && addr == ADDR_CTRL;
    wire wr_istat = wr_stb && addr == ADDR_IRQ_STAT;
    wire wr_imask = wr_stb && addr == ADDR_IRQ_MASK;
    wire wr_rate = wr_stb && addr == ADDR_RATE;
    wire rd_result = rd_stb && addr == ADDR_RESULT;
    wire sw_start = wr_ctrl && wdata[CTRL_START_BIT];
    wire sw_stop = wr_ctrl && wdata[CTRL_STOP_BIT];
    wire hw_start = soc_in && !soc_d_r;
    wire start_req = (sw_start || hw_start) && en_r;
    wire result_taken = rd_result || dma_ack;
    wire conv_end = (div_r == '0);
    wire conv_tick = (state_r == ST_CONVERT) && conv_end;
    wire prime_done = (prime_r == PRIME_LAST);
    // Fourth sample lands in the history at its tick; take the result one cycle later
    wire pend_set = conv_tick && prime_done;
    wire res_valid = pend_r && cv.ready && (state_r == ST_CONVERT);
    wire [RES_W-1:0] res_mask = lowres_r ? {{RES_W_LOW{1'b1}}, {(RES_W-RES_W_LOW){1'b0}}}
                                        : {RES_W{1'b1}};
    wire [RES_W-1:0] res_val = cv.result & res_mask;
    wire eoc_event = res_valid;
    wire ovr_event = res_valid && done_r && !result_taken;
    wire [IRQ_W-1:0] irq_set = {ovr_event, eoc_event};
    wire [RATE_W-1:0] period = lowres_r ? (rate_r >> 1) : rate_r;

    // Next state
    state_type state_nxt;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_STANDBY: begin
                if (start_req) state_nxt = ST_CONVERT;
            end
            ST_CONVERT: begin
                if (sw_stop || !en_r) begin
                    state_nxt = ST_STANDBY;
                end else if (res_valid && mode_r == MODE_SINGLE) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (result_taken) state_nxt = ST_STANDBY;
            end
            default: state_nxt = ST_STANDBY;
        endcase
    end

    // Clear between samples in multi mode and at each start
    wire clear_now = (state_r == ST_STANDBY && start_req)
                  || (res_valid && is_multi(mode_r));

    assign cv.clear = clear_now;
    assign cv.tick = conv_tick;
    assign cv.sample = mod_sample;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_STANDBY;
            soc_d_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            soc_d_r <= soc_in;
        end
    end

    // Result pending after a primed conversion
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
        end else if (clk_en) begin
            pend_r <= pend_set;
        end
    end

    // Conversion period counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (clk_en) begin
            if (state_r != ST_CONVERT || conv_end) div_r <= period;
            else div_r <= div_r - 1'b1;
        end
    end

    // Priming count: three conversions before the first result
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prime_r <= '0;
        end else if (clk_en) begin
            if (clear_now) prime_r <= '0;
            else if (conv_tick && !prime_done) prime_r <= prime_r + 1'b1;
        end
    end

    // Control and configuration
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_SINGLE;
            en_r <= 1'b0;
            lowres_r <= 1'b0;
            rate_r <= RATE_RESET;
            irq_mask_r <= '0;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                mode_r <= mode_type'(wdata[CTRL_MODE_LSB +: 2]);
                en_r <= wdata[CTRL_EN_BIT];
                lowres_r <= wdata[CTRL_LOWRES_BIT];
            end
            if (wr_rate) rate_r <= wdata[RATE_W-1:0];
            if (wr_imask) irq_mask_r <= wdata[IRQ_W-1:0];
        end
    end

    // Result, done flag and end of conversion; a new result beats a read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= '0;
            done_r <= 1'b0;
            ovr_r <= 1'b0;
            eoc_out <= 1'b0;
        end else if (clk_en) begin
            if (res_valid) result_r <= res_val;
            if (res_valid) begin
                done_r <= 1'b1;
                eoc_out <= 1'b1;
            end else if (result_taken) begin
                done_r <= 1'b0;
                eoc_out <= 1'b0;
            end
            if (ovr_event) ovr_r <= 1'b1;
            else if (wr_ctrl) ovr_r <= 1'b0;
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
            irq <= 1'b0;
        end else if (clk_en) begin
            irq_stat_r <= (irq_stat_r & ~(wr_istat ? wdata[IRQ_W-1:0] : '0)) | irq_set;
            irq <= |(((irq_stat_r & ~(wr_istat ? wdata[IRQ_W-1:0] : '0)) | irq_set)
                     & irq_mask_r);
        end
    end

    // Modulator drive
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mod_run <= 1'b0;
            mod_clear <= 1'b0;
        end else if (clk_en) begin
            mod_run <= (state_nxt == ST_CONVERT);
            mod_clear <= clear_now;
        end
    end

    // Read data
    wire [DATA_W-1:0] ctrl_word = DATA_W'({lowres_r, mode_r, en_r, 1'b0}) ;
    wire [DATA_W-1:0] stat_word = DATA_W'({ovr_r, state_r != ST_STANDBY, done_r});
    wire [DATA_W-1:0] rd_mux =
        (addr == ADDR_CTRL)     ? ctrl_word :
        (addr == ADDR_STATUS)   ? stat_word :
        (addr == ADDR_RESULT)   ? DATA_W'(result_r) :
        (addr == ADDR_IRQ_STAT) ? DATA_W'(irq_stat_r) :
        (addr == ADDR_IRQ_MASK) ? DATA_W'(irq_mask_r) :
        (addr == ADDR_RATE)     ? DATA_W'(rate_r) : ZERO_WORD;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= ZERO_WORD;
        end else if (clk_en) begin
            rdata <= rd_stb ? rd_mux : ZERO_WORD;
        end
    end
endmodule // dsadc_conv_ctrl
`default_nettype wire

// *** bench/dsadc_conv_ctrl_props.sv ***
// Checker: port-level properties of the conversion controller
`default_nettype none
module dsadc_conv_ctrl_props
    import dsadc_ctrl_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    input wire logic                               clk_sys,
    input wire logic                               reset_n,
    input wire logic                               clk_en,
    input wire logic [dsadc_ctrl_pkg::ADDR_W-1:0]  addr,
    input wire logic [dsadc_ctrl_pkg::DATA_W-1:0]  wdata,
    input wire logic                               wr_stb,
    input wire logic                               rd_stb,
    input wire logic [dsadc_ctrl_pkg::DATA_W-1:0]  rdata,
    input wire logic                               soc_in,
    input wire logic                               dma_ack,
    input wire logic [RES_BITS-1:0]                mod_sample,
    input wire logic                               mod_run,
    input wire logic                               mod_clear,
    input wire logic                               eoc_out,
    input wire logic                               irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    wire logic res_rd = rd_stb && clk_en && addr == ADDR_RESULT;
    rdata_idle_a: assert property (
        $past(clk_en) && !$past(rd_stb) |-> rdata == ZERO_WORD)
        else $error("read data not zero outside a read");
    eoc_drop_a: assert property (
        (res_rd || (dma_ack && clk_en)) && !mod_run |=> !eoc_out)
        else $error("end of conversion stayed high after read");
    eoc_hold_a: assert property (
        eoc_out && clk_en && !res_rd && !dma_ack && !wr_stb |=> eoc_out)
        else $error("end of conversion dropped without read");
    clk_freeze_a: assert property (
        !clk_en |=> $stable(eoc_out) && $stable(mod_run) && $stable(irq))
        else $error("state moved while clock enable low");
    clear_pulse_a: assert property (
        mod_clear && clk_en |=> !mod_clear)
        else $error("decimator clear longer than one cycle");
    run_start_a: assert property (
        $rose(mod_run) |-> mod_clear)
        else $error("conversion began without clearing history");
    eoc_cause_a: assert property (
        $rose(eoc_out) |-> $past(mod_run))
        else $error("end of conversion without a conversion");
    irq_cause_a: assert property (
        $rose(irq) |-> eoc_out || $past(eoc_out) || $past(wr_stb))
        else $error("interrupt raised without an event");
endmodule // dsadc_conv_ctrl_props
bind dsadc_conv_ctrl dsadc_conv_ctrl_props #(.RES_BITS(RES_BITS)) dsadc_conv_ctrl_props_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .soc_in(soc_in), .dma_ack(dma_ack),
    .mod_sample(mod_sample), .mod_run(mod_run), .mod_clear(mod_clear), .eoc_out(eoc_out),
    .irq(irq));
`default_nettype wire

// *** bench/dsadc_dma_model.sv ***
// Partner: DMA reader that takes each result after a set lag
`default_nettype none
module dsadc_dma_model (
    input  wire logic       clk_sys,
    input  wire logic       eoc_out,
    input  wire logic       auto_on,
    input  wire logic [3:0] lag,
    output var  logic       dma_ack,
    output var  logic [7:0] acks
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r = 4'h0;
    initial dma_ack = 1'b0;
    initial acks = 8'h00;
    always @(posedge clk_sys) begin
        dma_ack <= 1'b0;
        if (!auto_on || !eoc_out || dma_ack) begin
            wait_r <= 4'h0;
        end else if (wait_r == lag) begin
            dma_ack <= 1'b1;
            acks <= acks + 8'h01;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // dsadc_dma_model
`default_nettype wire

// *** bench/dsadc_conv_ctrl_tb.sv ***
// Bench: self-checking test of the conversion controller
`default_nettype none
module dsadc_conv_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dsadc_ctrl_pkg::*;
    localparam int P = 4;
    logic clk_sys = 0, reset_n = 0, clk_en = 1, wr_stb = 0, rd_stb = 0, soc_in = 0;
    logic              auto_on = 0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 32'h0, d;
    logic [11:0]       mod_sample = 12'h5a3;
    wire logic [DATA_W-1:0] rdata;
    wire logic         dma_ack, mod_run, mod_clear, eoc_out, irq;
    wire logic [7:0]   acks;
    int mismatches = 0, samples_checked = 0, n, cyc = 0, clears = 0;
    dsadc_conv_ctrl #(.RES_BITS(12), .RATE_BITS(16)) dsadc_conv_ctrl_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .soc_in(soc_in), .dma_ack(dma_ack),
        .mod_sample(mod_sample), .mod_run(mod_run), .mod_clear(mod_clear), .eoc_out(eoc_out),
        .irq(irq));
    dsadc_dma_model dsadc_dma_model_i (.clk_sys(clk_sys), .eoc_out(eoc_out),
        .auto_on(auto_on), .lag(4'h2), .dma_ack(dma_ack), .acks(acks));
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (mod_clear === 1'b1 && clk_en) clears++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_eoc;
        n = 0;
        while (eoc_out !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n >= 200) mismatches++;
    endtask
    function automatic logic [31:0] cw(input mode_type m, input logic lo, input logic st);
        return {26'h0, 1'b0, lo, m, 1'b1, st};
    endfunction
    task automatic stop_run;
        wr(ADDR_CTRL, 32'h20);
        repeat (4 * P) @(posedge clk_sys);
        rd(ADDR_RESULT);
        #1 chk("stopped", 32'({mod_run, eoc_out}), 32'h0);
    endtask
    task automatic t_regs;
        rd(ADDR_RATE);
        chk("rate", d, {16'h0, RATE_RESET});
        rd(ADDR_STATUS);
        chk("status", d, ZERO_WORD);
        rd(4'hf);
        chk("unmapped", d, ZERO_WORD);
        wr(ADDR_RATE, 32'(P - 1));
    endtask
    task automatic t_single(input logic lo, input logic hw);
        int per;
        logic [31:0] exp;
        per = lo ? (P - 1) / 2 + 1 : P;
        exp = lo ? {20'h0, mod_sample[11:4], 4'h0} : {20'h0, mod_sample};
        wr(ADDR_IRQ_MASK, {31'h0, !lo});
        wr(ADDR_CTRL, cw(MODE_SINGLE, lo, 1'b0));
        if (hw) begin
            @(posedge clk_sys);
            soc_in <= 1'b1;
            @(posedge clk_sys);
            soc_in <= 1'b0;
        end else wr(ADDR_CTRL, cw(MODE_SINGLE, lo, 1'b1));
        @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b1;
        wait_eoc();
        chk("single_time", 32'(n >= 4 * per - 3 && n <= 4 * per + 3), 32'h1);
        rd(ADDR_STATUS);
        chk("done", 32'(d[STAT_DONE_BIT]), 32'h1);
        chk("irq", 32'(irq), 32'(!lo));
        rd(ADDR_IRQ_STAT);
        chk("irq_stat", d, 32'h1);
        rd(ADDR_RESULT);
        chk("result", d, exp);
        chk("eoc_read", 32'(eoc_out), 32'h0);
        repeat (8 * P) @(posedge clk_sys);
        #1 chk("standby", 32'({mod_run, eoc_out}), 32'h0);
        wr(ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_sys);
        #1 chk("irq_clear", 32'(irq), 32'h0);
    endtask
    task automatic t_multi(input mode_type m);
        int c0;
        c0 = clears;
        @(posedge clk_sys);
        mod_sample <= 12'h111;
        wr(ADDR_CTRL, cw(m, 1'b0, 1'b0));
        wr(ADDR_CTRL, cw(m, 1'b0, 1'b1));
        wait_eoc();
        @(posedge clk_sys);
        mod_sample <= 12'h7e2;
        rd(ADDR_RESULT);
        chk("multi_first", d, 32'h111);
        wait_eoc();
        chk("multi_auto", 32'(n <= 4 * P + 2), 32'h1);
        chk("reprime", 32'(clears - c0 >= 2), 32'h1);
        rd(ADDR_RESULT);
        chk("multi_next", d, 32'h7e2);
        stop_run();
    endtask
    task automatic t_cont;
        int a0;
        int c0;
        auto_on <= 1'b1;
        wr(ADDR_CTRL, cw(MODE_CONT, 1'b0, 1'b0));
        wr(ADDR_CTRL, cw(MODE_CONT, 1'b0, 1'b1));
        wait_eoc();
        chk("cont_first", 32'(n <= 4 * P + 3), 32'h1);
        a0 = acks;
        c0 = clears;
        repeat (10 * P) @(posedge clk_sys);
        chk("cont_rate", 32'(acks - a0 >= 9 && acks - a0 <= 11), 32'h1);
        chk("cont_noprime", 32'(clears - c0), 32'h0);
        stop_run();
        auto_on <= 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_single(1'b0, 1'b0);
        t_single(1'b1, 1'b1);
        t_multi(MODE_MULTI);
        t_multi(MODE_TURBO);
        t_cont();
        results();
    end
endmodule // dsadc_conv_ctrl_tb
`default_nettype wire
